// >>> pas_port_access_strobe.sv
// Port access strobes and external memory address drive
`timescale 1ns/1ps
`default_nettype none
module pas_port_access_strobe (
  // Clock and reset
  input  wire logic                                 clk_in,
  input  wire logic                                 reset_n_in,
  // Processor control
  input  wire logic                                 port_strobe_enable_in,
  input  wire logic                                 cpu_port_rd_in,
  input  wire logic                                 cpu_port_wr_in,
  input  wire logic [pas_pkg::PAS_PORT_W-1:0]       cpu_wdata_in,
  input  wire logic [pas_pkg::PAS_PORT_W-1:0]       cpu_dir_in,
  output logic      [pas_pkg::PAS_PORT_W-1:0]       cpu_rdata_out,
  // External memory request
  input  wire logic                                 mem_rd_in,
  input  wire logic                                 mem_wr_in,
  input  wire logic                                 mem_use_second_in,
  input  wire logic [pas_pkg::PAS_STRETCH_W-1:0]    mem_stretch_in,
  input  wire logic [pas_pkg::PAS_ADDR_W-1:0]       first_auto_pointer_in,
  input  wire logic [pas_pkg::PAS_ADDR_W-1:0]       second_auto_pointer_in,
  output logic                                      mem_busy_out,
  // Third io port pins
  input  wire logic [pas_pkg::PAS_PORT_W-1:0]       third_io_port_in,
  output logic      [pas_pkg::PAS_PORT_W-1:0]       third_io_port_out,
  output logic      [pas_pkg::PAS_PORT_W-1:0]       third_io_port_oe_out,
  // Strobes and address bus
  output logic                                      rd_strobe_n_out,
  output logic                                      wr_strobe_n_out,
  output logic      [pas_pkg::PAS_ADDR_W-1:0]       ext_addr_out,
  output logic                                      ext_addr_oe_out
);
  localparam int unsigned MCW = pas_pkg::PAS_STRETCH_W + 1;

  logic [pas_pkg::PAS_PORT_W-1:0] pin_s1_r;
  logic [pas_pkg::PAS_PORT_W-1:0] pin_s2_r;
  logic                           rd_trig;
  logic                           wr_trig;
  logic                           port_rd_act;
  logic                           port_wr_act;

  // Pins come from outside; two flops before use
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_r <= pas_pkg::PAS_PORT_RST;
      pin_s2_r <= pas_pkg::PAS_PORT_RST;
    end else begin
      pin_s1_r <= third_io_port_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Latch at the access itself, never at the strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_rdata_out <= pas_pkg::PAS_PORT_RST;
    end else if (cpu_port_rd_in) begin
      cpu_rdata_out <= pin_s2_r;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      third_io_port_out    <= pas_pkg::PAS_PORT_RST;
      third_io_port_oe_out <= '0;
    end else begin
      third_io_port_oe_out <= cpu_dir_in;
      if (cpu_port_wr_in) begin
        third_io_port_out <= cpu_wdata_in;
      end
    end
  end

  assign rd_trig = port_strobe_enable_in && cpu_port_rd_in;
  assign wr_trig = port_strobe_enable_in && cpu_port_wr_in;

  // One cycle less here: the pin flop below adds it back
  // Accesses two cycles apart cut a strobe short; the core never spaces them so
  pas_strobe_gen #(
    .DELAY (pas_pkg::PAS_RD_DELAY - 1),
    .WIDTH (pas_pkg::PAS_STRB_WIDTH)
  ) u_rd_gen (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .trig_in    (rd_trig),
    .strb_out   (port_rd_act)
  );

  pas_strobe_gen #(
    .DELAY (pas_pkg::PAS_WR_DELAY - 1),
    .WIDTH (pas_pkg::PAS_STRB_WIDTH)
  ) u_wr_gen (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .trig_in    (wr_trig),
    .strb_out   (port_wr_act)
  );

  // External memory cycle
  logic                 mem_busy_r;
  logic                 mem_busy_nxt;
  logic [MCW-1:0]       mem_cnt_r;
  logic [MCW-1:0]       mem_cnt_nxt;
  logic [MCW-1:0]       mem_last_r;
  logic                 mem_wr_r;
  logic                 mem_sec_r;
  logic [pas_pkg::PAS_ADDR_W-1:0] mem_addr_r;
  logic                 mem_req;
  logic                 mem_strb_nxt;

  assign mem_req = (mem_rd_in || mem_wr_in) && !mem_busy_r;

  always_comb begin
    mem_busy_nxt = mem_busy_r;
    mem_cnt_nxt  = mem_cnt_r;
    if (mem_req) begin
      mem_busy_nxt = 1'b1;
      mem_cnt_nxt  = '0;
    end else if (mem_busy_r) begin
      if (mem_cnt_r == mem_last_r) begin
        mem_busy_nxt = 1'b0;
        mem_cnt_nxt  = '0;
      end else begin
        mem_cnt_nxt = mem_cnt_r + MCW'(1);
      end
    end
  end

  // Strobe covers every cycle but the first address setup cycle
  assign mem_strb_nxt = mem_busy_nxt && (mem_cnt_nxt != '0);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_busy_r <= 1'b0;
      mem_cnt_r  <= '0;
      mem_last_r <= '0;
      mem_wr_r   <= 1'b0;
      mem_sec_r  <= 1'b0;
      mem_addr_r <= '0;
    end else begin
      mem_busy_r <= mem_busy_nxt;
      mem_cnt_r  <= mem_cnt_nxt;
      if (mem_req) begin
        mem_last_r <= MCW'(pas_pkg::PAS_MEM_BASE - 1) + MCW'(mem_stretch_in);
        mem_wr_r   <= mem_wr_in;
        mem_sec_r  <= mem_use_second_in;
        mem_addr_r <= mem_use_second_in ? second_auto_pointer_in : first_auto_pointer_in;
      end
    end
  end

  logic sec_nxt;
  logic wr_nxt;
  logic [pas_pkg::PAS_ADDR_W-1:0] addr_nxt;
  assign sec_nxt  = mem_req ? mem_use_second_in : mem_sec_r;
  assign wr_nxt   = mem_req ? mem_wr_in : mem_wr_r;
  assign addr_nxt = mem_req ? (mem_use_second_in ? second_auto_pointer_in
                                                 : first_auto_pointer_in) : mem_addr_r;

  // Pin flops; port and memory strobes share the two pins
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_strobe_n_out <= 1'b1;
      wr_strobe_n_out <= 1'b1;
      ext_addr_out    <= '0;
      ext_addr_oe_out <= 1'b0;
      mem_busy_out    <= 1'b0;
    end else begin
      rd_strobe_n_out <= !(port_rd_act || (mem_strb_nxt && !wr_nxt));
      wr_strobe_n_out <= !(port_wr_act || (mem_strb_nxt && wr_nxt));
      ext_addr_out    <= addr_nxt;
      ext_addr_oe_out <= mem_busy_nxt && (sec_nxt || mem_strb_nxt);
      mem_busy_out    <= mem_busy_nxt;
    end
  end

  // Checks
  logic mem_idle;
  assign mem_idle = !mem_busy_r && !mem_busy_out;

  chk_rd_delay_width: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_trig && mem_idle ##1 (!rd_trig && mem_idle) [*2] |->
      rd_strobe_n_out ##1 !rd_strobe_n_out ##1 !rd_strobe_n_out ##1 rd_strobe_n_out)
    else $error("read strobe timing wrong");
  chk_wr_delay_width: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_trig && mem_idle ##1 (!wr_trig && mem_idle) [*2] |->
      wr_strobe_n_out ##1 !wr_strobe_n_out ##1 !wr_strobe_n_out ##1 wr_strobe_n_out)
    else $error("write strobe timing wrong");
  chk_strb_two_cyc: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(wr_strobe_n_out) && !$past(wr_trig) && mem_idle |->
      ##1 !wr_strobe_n_out ##1 wr_strobe_n_out)
    else $error("port strobe not two cycles");
  chk_disabled_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !port_strobe_enable_in && (cpu_port_rd_in || cpu_port_wr_in) && !$past(rd_trig)
      && !$past(wr_trig) && !port_rd_act && !port_wr_act |->
      ##2 !port_rd_act && !port_wr_act)
    else $error("strobe started while disabled");
  chk_enable_gates: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(port_rd_act) |-> $past(port_strobe_enable_in, 2) && $past(cpu_port_rd_in, 2))
    else $error("read strobe without enabled read");
  chk_rd_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cpu_port_rd_in |=> cpu_rdata_out == $past(pin_s2_r))
    else $error("read data not latched at access");
  chk_rd_no_sample: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !rd_strobe_n_out && !$past(cpu_port_rd_in) |-> $stable(cpu_rdata_out))
    else $error("port sampled on read strobe");
  chk_first_ptr: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ext_addr_oe_out && !mem_sec_r |-> (!rd_strobe_n_out || !wr_strobe_n_out))
    else $error("first pointer address outside strobe");
  chk_second_ptr: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mem_busy_out && mem_sec_r |-> ext_addr_oe_out && ext_addr_out == mem_addr_r)
    else $error("second pointer address not held");

  cov_port_read:  cover property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_trig ##3 !rd_strobe_n_out);
  cov_port_write: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_trig ##3 !wr_strobe_n_out);
  cov_port_off:   cover property (@(posedge clk_in) disable iff (!reset_n_in)
    !port_strobe_enable_in && cpu_port_rd_in);
  cov_mem_second: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    mem_req && mem_use_second_in && mem_stretch_in != '0);
endmodule
`default_nettype wire

// >>> pas_pkg.sv
// Constants shared by the port access strobe block
package pas_pkg;
  localparam int unsigned PAS_PORT_W      = 8;
  localparam int unsigned PAS_ADDR_W      = 16;
  localparam int unsigned PAS_STRETCH_W   = 3;
  // Cycles from port access to strobe, and strobe width
  localparam int unsigned PAS_RD_DELAY    = 3;
  localparam int unsigned PAS_WR_DELAY    = 3;
  localparam int unsigned PAS_STRB_WIDTH  = 2;
  // Shortest external memory cycle before stretching
  localparam int unsigned PAS_MEM_BASE    = 2;
  localparam logic [PAS_PORT_W-1:0] PAS_PORT_RST = 8'h00;
endpackage

// >>> pas_strobe_gen.sv
// Delayed fixed-width pulse generator for one port strobe
`timescale 1ns/1ps
`default_nettype none
module pas_strobe_gen #(
  parameter int unsigned DELAY = 2,
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // Trigger and pulse
  input  wire logic trig_in,
  output logic      strb_out
);
  localparam int unsigned LAST = DELAY + WIDTH - 1;
  localparam int unsigned CW   = $clog2(LAST + 1);

  // Refused at elaboration: a zero delay or width has no pulse to count
  if (DELAY < 1 || WIDTH < 1) begin : g_param_check
    $error("pas_strobe_gen: DELAY and WIDTH must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // A new access restarts the sequence; the later access wins
  always_comb begin
    if (trig_in) begin
      cnt_nxt = CW'(1);
    end else if (cnt_r != '0 && cnt_r < CW'(LAST)) begin
      cnt_nxt = cnt_r + CW'(1);
    end else begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strb_out <= 1'b0;
    end else begin
      strb_out <= (cnt_nxt >= CW'(DELAY)) && (cnt_nxt <= CW'(LAST));
    end
  end
endmodule
`default_nettype wire

// >>> pas_periph_model.sv
// Peripheral that hands a new byte to the port after each read strobe
`timescale 1ns/1ps
`default_nettype none
module pas_periph_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Port side
  input  wire logic       rd_strobe_n_in,
  output logic      [7:0] data_out
);
  logic strb_d_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strb_d_r <= 1'b1;
      data_out <= 8'ha5;
    end else begin
      strb_d_r <= rd_strobe_n_in;
      // Byte held through the pulse, next one only once it ends
      if (rd_strobe_n_in && !strb_d_r) data_out <= data_out + 8'h11;
    end
  end
endmodule
`default_nettype wire

// >>> pas_port_access_strobe_bench.sv
// Self-checking bench for the port access strobe block
`timescale 1ns/1ps
`default_nettype none
module pas_port_access_strobe_bench;
  logic        clk_in     = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        en = 1'b0, prd = 1'b0, pwr = 1'b0, mrd = 1'b0, mwr = 1'b0, msec = 1'b0;
  logic [7:0]  wdata = 8'h00, dir = 8'h00, exp_byte = 8'ha5;
  logic [2:0]  stretch = 3'h0;
  logic [15:0] ptr1 = 16'h1234, ptr2 = 16'hbeef;
  logic [7:0]  rdata, pout, poe, periph;
  logic [15:0] addr;
  logic        busy, rd_n, wr_n, aoe;
  // Pins resolve per bit between our drive and the peripheral
  wire logic [7:0] pins = (poe & pout) | (~poe & periph);
  int failures = 0;
  int n_tests  = 0;

  always #12.5 clk_in = ~clk_in;

  pas_port_access_strobe pas_port_access_strobe_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .port_strobe_enable_in(en),
    .cpu_port_rd_in(prd), .cpu_port_wr_in(pwr), .cpu_wdata_in(wdata), .cpu_dir_in(dir),
    .cpu_rdata_out(rdata), .mem_rd_in(mrd), .mem_wr_in(mwr), .mem_use_second_in(msec),
    .mem_stretch_in(stretch), .first_auto_pointer_in(ptr1),
    .second_auto_pointer_in(ptr2), .mem_busy_out(busy), .third_io_port_in(pins),
    .third_io_port_out(pout), .third_io_port_oe_out(poe), .rd_strobe_n_out(rd_n),
    .wr_strobe_n_out(wr_n), .ext_addr_out(addr), .ext_addr_oe_out(aoe)
  );

  pas_periph_model pas_periph_model_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .rd_strobe_n_in(rd_n), .data_out(periph)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Port access; direction settles first so the synchroniser sees stable pins
  task automatic port_op(input logic is_wr, input logic on, input logic [7:0] d);
    logic lo;
    @(negedge clk_in);
    en = on;
    wdata = d;
    dir = is_wr ? 8'hff : 8'h00;
    repeat (3) @(negedge clk_in);
    prd = ~is_wr;
    pwr = is_wr;
    @(negedge clk_in);
    prd = 1'b0;
    pwr = 1'b0;
    for (int k = 1; k <= 5; k++) begin
      @(negedge clk_in);
      lo = on && (k == 2 || k == 3);
      check(is_wr ? wr_n : rd_n, !lo);
      check(is_wr ? rd_n : wr_n, 1'b1);
      if (k == 1) check(is_wr ? {poe, pout} : rdata, is_wr ? {8'hff, d} : exp_byte);
    end
    if (on && !is_wr) exp_byte = exp_byte + 8'h11;
  endtask

  task automatic mem_op(input logic is_wr, input logic sec, input logic [2:0] s);
    logic lo;
    @(negedge clk_in);
    mrd = ~is_wr;
    mwr = is_wr;
    msec = sec;
    stretch = s;
    @(negedge clk_in);
    mrd = 1'b0;
    mwr = 1'b0;
    for (int k = 1; k <= s + 3; k++) begin
      @(negedge clk_in);
      lo = k <= s + 1;
      check(busy, k <= s + 1);
      check(is_wr ? wr_n : rd_n, !lo);
      check(aoe, sec ? (k <= s + 1) : lo);
      if (aoe === 1'b1) check(addr, sec ? ptr2 : ptr1);
    end
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'b1;
    port_op(1'b0, 1'b1, 8'h00);
    port_op(1'b0, 1'b1, 8'h00);
    port_op(1'b0, 1'b0, 8'h00);
    port_op(1'b1, 1'b1, 8'h3c);
    port_op(1'b1, 1'b0, 8'hc3);
    port_op(1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) mem_op(i[0], i[1], 3'(i * 2));
    end_sim();
  end

  // Run needs about 112 cycles; far more means a hang
  initial begin
    #20000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
